// File: hw/scau_top.sv
`timescale 1ns/1ps
`include "scau_defines.svh"

// Notes on behaviour
// - Zero shift length passes the operand unchanged and leaves carry alone.
// - Arithmetic right shift moves bits down and fills the top with the sign.
// - Flag-setting arithmetic right shift loads carry from bit n-1.
// - Arithmetic right by 32 or more gives all sign bits; carry takes bit 31.
// - Logical right shift zero-fills the top; flag form loads carry from bit n-1.
// - Logical shifts of 32 or more give zero; lengths above 32 clear carry.
// - Logical left shift zero-fills the bottom; flag form loads carry from bit 32-n.
// - Rotate right wraps low bits to the top; flag form loads carry from bit n-1.
// - Rotate right by 32 returns the operand; carry takes bit 31.
// - Rotate right above 32 equals rotate by the length minus 32.
// - Words need word alignment, halfwords halfword alignment, bytes always fit.
// - Unaligned accesses are never performed and raise a hard fault instead.
// - The program counter read as an operand is current address plus four.
// - A branch with link writes the link value with bit 0 forced to one.

module scau_top (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic                           exec_valid,
  input  wire scau_pkg::scau_shift_op_type    shift_op,
  input  wire logic                           shift_flagset,
  input  wire logic [7:0]                     shift_len,
  input  wire logic [31:0]                    source_operand_reg,
  input  wire logic                           carry_in,
  input  wire logic                           mem_req,
  input  wire scau_pkg::scau_access_size_type mem_size,
  input  wire logic [31:0]                    mem_addr,
  input  wire logic [31:0]                    instr_addr,
  input  wire logic                           link_req,
  input  wire logic [31:0]                    return_addr,
  output logic [31:0]                         shift_result,
  output logic                                shift_done,
  output logic                                carry_update,
  output logic                                carry_value,
  output logic                                mem_grant,
  output logic                                hard_fault_exception,
  output logic [31:0]                         pc_operand,
  output logic                                link_write,
  output logic [31:0]                         link_register
);
  import scau_pkg::*;

  logic [31:0] shift_out;
  logic        carry_out;

  scau_shifter u_shifter (
    .shift_op           (shift_op),
    .shift_len          (shift_len),
    .source_operand_reg (source_operand_reg),
    .carry_in           (carry_in),
    .shift_out          (shift_out),
    .carry_out          (carry_out)
  );

  wire        len_zero     = (shift_len == 8'h00);
  wire        next_cy_load = exec_valid && shift_flagset && !len_zero;
  wire        half_ok      = !mem_addr[`SCAU_HALF_ALIGN_POS];
  wire        word_ok      = (mem_addr[`SCAU_WORD_ALIGN_MSB:0] == 2'h0);
  // Multiple-word transfers share the word test; bytes can never be misplaced.
  wire        aligned      = (mem_size == size_byte) ? 1'h1
                           : (mem_size == size_half) ? half_ok : word_ok;
  wire        next_grant   = mem_req && aligned;
  wire        next_fault   = mem_req && !aligned;
  wire [31:0] next_pc      = instr_addr + `SCAU_PC_OFFSET;
  wire [31:0] next_link    = return_addr | (32'h0000_0001 << `SCAU_STATE_BIT_POS);

  // The shift settles in the execute cycle and is captured at its end.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_result <= `SCAU_RESULT_RST;
      shift_done   <= 1'h0;
      carry_update <= 1'h0;
      carry_value  <= `SCAU_CARRY_RST;
    end else begin
      shift_done   <= exec_valid;
      carry_update <= next_cy_load;
      if (exec_valid) begin
        shift_result <= shift_out;
      end
      if (next_cy_load) begin
        carry_value <= carry_out;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_grant            <= 1'h0;
      hard_fault_exception <= 1'h0;
    end else begin
      mem_grant            <= next_grant;
      hard_fault_exception <= next_fault;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_operand    <= `SCAU_PC_RST;
      link_write    <= 1'h0;
      link_register <= `SCAU_LINK_RST;
    end else begin
      link_write <= link_req;
      if (exec_valid) begin
        pc_operand <= next_pc;
      end
      if (link_req) begin
        link_register <= next_link;
      end
    end
  end

  // Helper wires for the checks below.
  wire [4:0] chk_dn   = 5'(shift_len[4:0] - 5'h01);
  wire [4:0] chk_up   = 5'(5'h00 - shift_len[4:0]);
  wire       chk_mid  = !len_zero && (shift_len < `SCAU_WORD_LEN);
  wire       chk_big  = (shift_len >= `SCAU_WORD_LEN);
  wire       chk_word = (shift_len == `SCAU_WORD_LEN);
  wire       is_asr   = (shift_op == op_arith_shift_right);
  wire       is_lsr   = (shift_op == op_logic_shift_right);
  wire       is_lsl   = (shift_op == op_logic_shift_left);
  wire       is_ror   = (shift_op == op_rotate_right);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence bad_access_s;
    mem_req && !aligned;
  endsequence

  sequence fault_raised_s;
    hard_fault_exception && !mem_grant;
  endsequence

  shift_zero_pass_a: assert property (
    exec_valid && len_zero |=> shift_result == $past(source_operand_reg) && !carry_update)
    else $error("zero-length shift changed operand or carry");
  asr_sign_fill_a: assert property (
    exec_valid && is_asr && chk_mid |=> shift_result[31] == $past(source_operand_reg[31]))
    else $error("arithmetic shift lost the sign");
  asr_carry_a: assert property (
    exec_valid && shift_flagset && is_asr && chk_mid
    |=> carry_update && carry_value == $past(source_operand_reg[chk_dn]))
    else $error("arithmetic shift carry wrong");
  asr_wide_a: assert property (
    exec_valid && shift_flagset && is_asr && chk_big
    |=> shift_result == {32{$past(source_operand_reg[31])}}
        && carry_value == $past(source_operand_reg[31]))
    else $error("wide arithmetic shift wrong");
  lsr_carry_a: assert property (
    exec_valid && shift_flagset && is_lsr && chk_mid
    |=> carry_update && carry_value == $past(source_operand_reg[chk_dn])
        && shift_result[31] == 1'h0)
    else $error("logical right carry wrong");
  wide_zero_a: assert property (
    exec_valid && shift_flagset && (is_lsr || is_lsl) && chk_big && !chk_word
    |=> shift_result == 32'h0000_0000 && carry_value == 1'h0)
    else $error("wide logical shift not zero");
  lsl_carry_a: assert property (
    exec_valid && shift_flagset && is_lsl && chk_mid
    |=> carry_value == $past(source_operand_reg[chk_up]) && shift_result[0] == 1'h0)
    else $error("logical left carry wrong");
  ror_carry_a: assert property (
    exec_valid && shift_flagset && is_ror && chk_mid
    |=> carry_value == $past(source_operand_reg[chk_dn]) && carry_value == shift_result[31])
    else $error("rotate carry wrong");
  ror_word_a: assert property (
    exec_valid && shift_flagset && is_ror && chk_word
    |=> shift_result == $past(source_operand_reg) && carry_value == $past(source_operand_reg[31]))
    else $error("rotate by 32 wrong");
  flagset_only_a: assert property (
    exec_valid && !shift_flagset |=> shift_done && !carry_update)
    else $error("carry updated without flag setting");
  lsl_word_carry_a: assert property (
    exec_valid && shift_flagset && is_lsl && chk_word
    |=> carry_value == $past(source_operand_reg[0]) && shift_result == 32'h0000_0000)
    else $error("left shift by 32 carry wrong");
  half_grant_a: assert property (
    mem_req && mem_size == size_half && !mem_addr[0] |=> mem_grant && !hard_fault_exception)
    else $error("aligned halfword refused");
  misalign_fault_a: assert property (
    bad_access_s |=> fault_raised_s)
    else $error("unaligned access not faulted");
  pc_plus_four_a: assert property (
    exec_valid |=> pc_operand == $past(instr_addr) + 32'h0000_0004)
    else $error("program counter operand wrong");
  link_bit_a: assert property (
    link_req |=> link_write && link_register[0] && link_register[31:1] == $past(return_addr[31:1]))
    else $error("link value bit 0 not set");

endmodule

// File: pkg/scau_defines.svh
`ifndef SCAU_DEFINES_SVH
`define SCAU_DEFINES_SVH

`define SCAU_WORD_LEN       8'h20
`define SCAU_PC_OFFSET      32'h0000_0004
`define SCAU_STATE_BIT_POS  0
`define SCAU_HALF_ALIGN_POS 0
`define SCAU_WORD_ALIGN_MSB 1
`define SCAU_RESULT_RST     32'h0000_0000
`define SCAU_PC_RST         32'h0000_0000
`define SCAU_LINK_RST       32'h0000_0001
`define SCAU_CARRY_RST      1'h0

`endif

// File: pkg/scau_pkg.sv
package scau_pkg;

  typedef enum logic [1:0] {
    op_arith_shift_right = 2'h0,
    op_logic_shift_right = 2'h1,
    op_logic_shift_left  = 2'h2,
    op_rotate_right      = 2'h3
  } scau_shift_op_type;

  typedef enum logic [1:0] {
    size_byte  = 2'h0,
    size_half  = 2'h1,
    size_word  = 2'h2,
    size_multi = 2'h3
  } scau_access_size_type;

endpackage

// File: hw/scau_shifter.sv
`timescale 1ns/1ps
`include "scau_defines.svh"

module scau_shifter (
  input  wire scau_pkg::scau_shift_op_type shift_op,
  input  wire logic [7:0]                  shift_len,
  input  wire logic [31:0]                 source_operand_reg,
  input  wire logic                        carry_in,
  output logic [31:0]                      shift_out,
  output logic                             carry_out
);
  import scau_pkg::*;

  wire        len_zero  = (shift_len == 8'h00);
  wire        len_big   = (shift_len >= `SCAU_WORD_LEN);
  wire        len_word  = (shift_len == `SCAU_WORD_LEN);
  wire [4:0]  len_low   = shift_len[4:0];
  wire [4:0]  idx_down  = 5'(len_low - 5'h01);
  wire [4:0]  idx_up    = 5'(5'h00 - len_low);
  wire [63:0] rot_full  = {source_operand_reg, source_operand_reg} >> len_low;

  wire [31:0] asr_res   = len_big ? {32{source_operand_reg[31]}}
                                  : 32'($signed(source_operand_reg) >>> len_low);
  wire        asr_cy    = len_big ? source_operand_reg[31] : source_operand_reg[idx_down];
  wire [31:0] lsr_res   = len_big ? 32'h0000_0000 : (source_operand_reg >> len_low);
  wire        lsr_cy    = len_word ? source_operand_reg[31]
                        : (len_big ? 1'h0 : source_operand_reg[idx_down]);
  wire [31:0] lsl_res   = len_big ? 32'h0000_0000 : (source_operand_reg << len_low);
  wire        lsl_cy    = len_word ? source_operand_reg[0]
                        : (len_big ? 1'h0 : source_operand_reg[idx_up]);
  // A length above 32 wraps by whole words, so only the low five bits matter.
  wire [31:0] ror_res   = rot_full[31:0];
  wire        ror_cy    = (len_low == 5'h00) ? source_operand_reg[31]
                                             : source_operand_reg[idx_down];

  always_comb begin
    shift_out = source_operand_reg;
    carry_out = carry_in;
    if (!len_zero) begin
      case (shift_op)
        op_arith_shift_right: begin
          shift_out = asr_res;
          carry_out = asr_cy;
        end
        op_logic_shift_right: begin
          shift_out = lsr_res;
          carry_out = lsr_cy;
        end
        op_logic_shift_left: begin
          shift_out = lsl_res;
          carry_out = lsl_cy;
        end
        op_rotate_right: begin
          shift_out = ror_res;
          carry_out = ror_cy;
        end
        default: begin
          shift_out = source_operand_reg;
          carry_out = carry_in;
        end
      endcase
    end
  end

endmodule

// File: testbench/scau_flag_model.sv
`timescale 1ns/1ps

// Flag register on the far side: it keeps the carry and feeds it back as carry_in.
module scau_flag_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic carry_update,
  input  wire logic carry_value,
  output logic      carry_flag
);
  // The flag moves only on an update pulse, so zero-length shifts leave it alone.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      carry_flag <= 1'b0;
    end else if (carry_update) begin
      carry_flag <= carry_value;
    end
  end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps

module tb;
  import scau_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 exec_valid = 1'b0;
  scau_shift_op_type    shift_op = op_arith_shift_right;
  logic                 shift_flagset = 1'b0;
  logic [7:0]           shift_len = 8'h00;
  logic [31:0]          source_operand_reg = 32'h0000_0000;
  logic                 carry_in;
  logic                 mem_req = 1'b0;
  scau_access_size_type mem_size = size_byte;
  logic [31:0]          mem_addr = 32'h0000_0000;
  logic [31:0]          instr_addr = 32'h0000_0000;
  logic                 link_req = 1'b0;
  logic [31:0]          return_addr = 32'h0000_0000;
  logic [31:0]          shift_result, pc_operand, link_register;
  logic                 shift_done, carry_update, carry_value;
  logic                 mem_grant, hard_fault_exception, link_write;
  int                   failures = 0;
  int                   n_compared = 0;
  logic                 exp_c = 1'b0;

  always #50 sys_clk = ~sys_clk;

  scau_top dut (.sys_clk(sys_clk), .rst(rst), .exec_valid(exec_valid), .shift_op(shift_op),
    .shift_flagset(shift_flagset), .shift_len(shift_len),
    .source_operand_reg(source_operand_reg), .carry_in(carry_in), .mem_req(mem_req),
    .mem_size(mem_size), .mem_addr(mem_addr), .instr_addr(instr_addr), .link_req(link_req),
    .return_addr(return_addr), .shift_result(shift_result), .shift_done(shift_done),
    .carry_update(carry_update), .carry_value(carry_value), .mem_grant(mem_grant),
    .hard_fault_exception(hard_fault_exception), .pc_operand(pc_operand),
    .link_write(link_write), .link_register(link_register));

  scau_flag_model flags (.sys_clk(sys_clk), .rst(rst), .carry_update(carry_update),
    .carry_value(carry_value), .carry_flag(carry_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Returns {carry, result}; carry is ignored when the length is zero.
  function automatic logic [32:0] ref_shift(input int o, input int n, input logic [31:0] s);
    int m;
    m = n % 32;
    if (n == 0) return {1'b0, s};
    case (o)
      0: return (n >= 32) ? {s[31], {32{s[31]}}} : {s[n-1], 32'($signed(s) >>> n)};
      1: return (n >= 32) ? {(n == 32) & s[31], 32'h0000_0000} : {s[n-1], s >> n};
      2: return (n >= 32) ? {(n == 32) & s[0], 32'h0000_0000} : {s[32-n], s << n};
      default: return (m == 0) ? {s[31], s} : {s[m-1], (s >> m) | (s << (32 - m))};
    endcase
  endfunction

  task automatic check_reset();
    check("shift_result", shift_result, 32'h0000_0000);
    check("pc_operand", pc_operand, 32'h0000_0000);
    check("carry_value", 32'(carry_value), 32'h0000_0000);
    check("link_register", link_register, 32'h0000_0001);
    check("pulses", {shift_done, carry_update, mem_grant, hard_fault_exception, link_write},
          32'h0000_0000);
  endtask

  task automatic run_shift(input int o, input int n, input logic fs, input logic [31:0] s);
    logic [32:0] r;
    r = ref_shift(o, n, s);
    @(posedge sys_clk);
    exec_valid <= 1'b1;
    shift_op <= scau_shift_op_type'(o);
    shift_len <= 8'(n);
    shift_flagset <= fs;
    source_operand_reg <= s;
    instr_addr <= {s[31:2], 2'b00};
    @(posedge sys_clk);
    exec_valid <= 1'b0;
    #1;
    if (fs && n != 0) exp_c = r[32];
    check("shift_result", shift_result, r[31:0]);
    check("shift_done", 32'(shift_done), 32'h1);
    check("carry_update", 32'(carry_update), 32'(fs && n != 0));
    check("carry_value", 32'(carry_value), 32'(exp_c));
    check("pc_operand", pc_operand, {s[31:2], 2'b00} + 32'h0000_0004);
    // The flag register takes the update pulse one edge after the result appears.
    @(posedge sys_clk);
    #1;
    check("carry_in", 32'(carry_in), 32'(exp_c));
  endtask

  task automatic run_all_shifts();
    int lens [9] = '{0, 1, 5, 31, 32, 33, 40, 64, 255};
    logic [31:0] srcs [2] = '{32'h8765_4321, 32'h4c3a_29b6};
    foreach (srcs[k]) for (int o = 0; o < 4; o++) foreach (lens[i]) begin
      run_shift(o, lens[i], 1'b1, srcs[k]);
      run_shift(o, lens[i], 1'b0, ~srcs[k]);
    end
  endtask

  // Requests go out back to back; each answer is judged while the next request is taken.
  task automatic run_mem();
    int s;
    int a;
    logic ok;
    for (int i = 0; i <= 16; i++) begin
      @(posedge sys_clk);
      mem_req <= (i < 16);
      mem_size <= scau_access_size_type'((i % 16) / 4);
      mem_addr <= 32'h2000_0010 | 32'(i % 4);
      if (i > 0) begin
        #1;
        s = (i - 1) / 4;
        a = (i - 1) % 4;
        ok = (s == 0) || (s == 1 && a % 2 == 0) || (s >= 2 && a == 0);
        check("mem_grant", 32'(mem_grant), 32'(ok));
        check("hard_fault", 32'(hard_fault_exception), 32'(!ok));
      end
    end
  endtask

  task automatic run_link(input logic [31:0] ra);
    @(posedge sys_clk);
    link_req <= 1'b1;
    return_addr <= ra;
    @(posedge sys_clk);
    link_req <= 1'b0;
    #1;
    check("link_write", 32'(link_write), 32'h1);
    check("link_register", link_register, {ra[31:1], 1'b1});
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check_reset();
    run_all_shifts();
    run_mem();
    run_link(32'h0000_1234);
    run_link(32'h0000_5679);
    summarize();
  end
endmodule
